/* mpmr_regs.sv */
// monitor / playback-only mode register bank with AXI4-Lite slave;
// assumes one outstanding write and one outstanding read per master
//
// Functional notes
// - monitor source code 00 routes the mic preamp, 01 the first opamp.
// - monitor source code 11 connects no source, only the line input.
// - monitor bit 4 set mutes the line input in monitor mode.
// - monitor bit 1 picks full slider mode while bit 7 at index 0x17 is set, clear picks basic slider.
// - bit 7 at index 0x17 enables slide switch power control.
// - monitor bit 0 set disables monitor mode under push button.
// - playback-only bit 7 reads as 1 and is never written.
// - playback-only bit 6 set disables playback-only mode.
// - playback-only bit 4 set enables mic preamp power save.
// - playback-only bit 1 switches the opamp right channel on.
// - playback-only bit 0 switches the opamp left channel on.
// - bits 7:6 at index 0x14 select the noise-cancel mode source.
//
// Implementation choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module mpmr_regs (
    input  wire logic                         i_sys_clk, // 20 MHz clock
    input  wire logic                         i_sys_rst, // async, high
    input  wire mpmr_pkg::mpmr_mode_t         i_mode,    // active mode
    input  wire logic [mpmr_pkg::ADDR_W-1:0]  i_awaddr,  // write address
    input  wire logic                         i_awvalid, // aw valid
    output var  logic                         o_awready, // aw ready
    input  wire logic [mpmr_pkg::DATA_W-1:0]  i_wdata,   // write data
    input  wire logic [3:0]                   i_wstrb,   // byte strobes
    input  wire logic                         i_wvalid,  // w valid
    output var  logic                         o_wready,  // w ready
    output var  logic [1:0]                   o_bresp,   // write response
    output var  logic                         o_bvalid,  // b valid
    input  wire logic                         i_bready,  // b ready
    input  wire logic [mpmr_pkg::ADDR_W-1:0]  i_araddr,  // read address
    input  wire logic                         i_arvalid, // ar valid
    output var  logic                         o_arready, // ar ready
    output var  logic [mpmr_pkg::DATA_W-1:0]  o_rdata,   // read data
    output var  logic [1:0]                   o_rresp,   // read response
    output var  logic                         o_rvalid,  // r valid
    input  wire logic                         i_rready,  // r ready
    output var  mpmr_pkg::mpmr_route_t        o_route    // analog controls
);
    import mpmr_pkg::*;

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    mpmr_regs_t        regs;
    logic [IDX_W-1:0]  aw_idx;
    logic [REG_W-1:0]  w_byte;
    logic              w_lane;
    logic              wr_commit;
    logic [REG_W-1:0]  wr_msk;
    logic [IDX_W-1:0]  ar_idx;
    logic              ar_take;

    // register value as seen by software
    function automatic logic [REG_W-1:0] rd_value(
        input logic [IDX_W-1:0] idx,
        input mpmr_regs_t       r
    );
        case (idx)
            IDX_NC:  rd_value = r.nc;
            IDX_MON: rd_value = r.mon;
            IDX_PBO: rd_value = r.pbo | PBO_FIXED;
            IDX_ECO: rd_value = r.eco;
            default: rd_value = RST_VAL;
        endcase
    endfunction

    // ------------------------------------------------------------------
    // write channels: address and data taken in either order
    // ------------------------------------------------------------------
    assign wr_commit = !o_awready && !o_wready && !o_bvalid;
    assign wr_msk    = wr_mask(aw_idx);

    always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_awready <= 1'b1;
            aw_idx    <= '0;
        end else if (o_awready && i_awvalid) begin
            o_awready <= 1'b0;
            aw_idx    <= i_awaddr[ADDR_W-1:IDX_LSB];
        end else if (o_bvalid && i_bready) begin
            o_awready <= 1'b1;
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_wready <= 1'b1;
            w_byte   <= RST_VAL;
            w_lane   <= 1'b0;
        end else if (o_wready && i_wvalid) begin
            o_wready <= 1'b0;
            w_byte   <= i_wdata[REG_W-1:0];
            w_lane   <= i_wstrb[0];
        end else if (o_bvalid && i_bready) begin
            o_wready <= 1'b1;
        end
    end

    // response follows the commit by one edge
    always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_bvalid <= 1'b0;
            o_bresp  <= RESP_OKAY;
        end else if (wr_commit) begin
            o_bvalid <= 1'b1;
            o_bresp  <= (wr_msk == RST_VAL) ? RESP_SLVERR : RESP_OKAY;
        end else if (o_bvalid && i_bready) begin
            o_bvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // register storage: only writable bits are kept
    // ------------------------------------------------------------------
    always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            regs <= {RST_VAL, RST_VAL, RST_VAL, RST_VAL};
        end else if (wr_commit && w_lane) begin
            case (aw_idx)
                IDX_NC:  regs.nc  <= w_byte & wr_msk;
                IDX_MON: regs.mon <= w_byte & wr_msk;
                IDX_PBO: regs.pbo <= w_byte & wr_msk;
                IDX_ECO: regs.eco <= w_byte & wr_msk;
                default: regs     <= regs;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // read channel: data valid on the edge that takes the address
    // ------------------------------------------------------------------
    assign ar_take = o_arready && i_arvalid;
    assign ar_idx  = i_araddr[ADDR_W-1:IDX_LSB];

    always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_arready <= 1'b1;
            o_rvalid  <= 1'b0;
            o_rdata   <= '0;
            o_rresp   <= RESP_OKAY;
        end else if (ar_take) begin
            o_arready <= 1'b0;
            o_rvalid  <= 1'b1;
            o_rdata   <= DATA_W'(rd_value(ar_idx, regs));
            o_rresp   <= (wr_mask(ar_idx) == RST_VAL) ?
                         RESP_SLVERR : RESP_OKAY;
        end else if (o_rvalid && i_rready) begin
            o_arready <= 1'b1;
            o_rvalid  <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // routing stage
    // ------------------------------------------------------------------
    mpmr_route u_route (
        .i_sys_clk (i_sys_clk),
        .i_sys_rst (i_sys_rst),
        .i_mode    (i_mode),
        .i_regs    (regs),
        .o_route   (o_route)
    );

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    sequence s_write_to(logic [IDX_W-1:0] idx, int unsigned b);
        wr_commit && w_lane && aw_idx == idx && w_byte[b];
    endsequence

    sequence s_route_settles;
        ##2 1'b1;
    endsequence

    property p_mon_mic;
        @(posedge i_sys_clk) disable iff (i_sys_rst)
        (i_mode == MODE_MONITOR && regs.mon[SRC_HI:SRC_LO] == SRC_MIC)
        |=> (o_route.hp_from_mic && !o_route.hp_from_opamp);
    endproperty
    a_mon_mic: assert property (p_mon_mic)
        else $error("monitor code 00 did not route the mic preamp");

    property p_mon_opamp;
        @(posedge i_sys_clk) disable iff (i_sys_rst)
        (i_mode == MODE_MONITOR && regs.mon[SRC_HI:SRC_LO] == SRC_OPAMP)
        |=> (o_route.hp_from_opamp && !o_route.hp_from_mic);
    endproperty
    a_mon_opamp: assert property (p_mon_opamp)
        else $error("monitor code 01 did not route the opamp");

    property p_mon_none;
        @(posedge i_sys_clk) disable iff (i_sys_rst)
        (i_mode == MODE_MONITOR && regs.mon[SRC_HI:SRC_LO] == SRC_NONE)
        |=> !(o_route.hp_from_mic || o_route.hp_from_opamp);
    endproperty
    a_mon_none: assert property (p_mon_none)
        else $error("monitor code 11 left a source connected");

    property p_mon_mute;
        @(posedge i_sys_clk) disable iff (i_sys_rst)
        (i_mode == MODE_MONITOR)
        |=> (o_route.line_in_on == !$past(regs.mon[LMUTE]));
    endproperty
    a_mon_mute: assert property (p_mon_mute)
        else $error("line input mute in monitor mode is wrong");

    property p_slider;
        @(posedge i_sys_clk) disable iff (i_sys_rst)
        (regs.eco[SLIDE_EN] && $changed(regs.mon[SLIDER]))
        |=> (o_route.full_slider == $past(regs.mon[SLIDER]));
    endproperty
    a_slider: assert property (p_slider)
        else $error("slider variant did not follow its bit");

    property p_slide_power;
        @(posedge i_sys_clk) disable iff (i_sys_rst)
        s_write_to(IDX_ECO, SLIDE_EN) |-> s_route_settles
        ##0 o_route.slide_power_on;
    endproperty
    a_slide_power: assert property (p_slide_power)
        else $error("slide power enable write did not take effect");

    property p_mon_disable;
        @(posedge i_sys_clk) disable iff (i_sys_rst)
        s_write_to(IDX_MON, DIS_MON) |-> s_route_settles
        ##0 !o_route.monitor_allowed;
    endproperty
    a_mon_disable: assert property (p_mon_disable)
        else $error("monitor disable write did not take effect");

    property p_test_bit;
        @(posedge i_sys_clk) disable iff (i_sys_rst)
        (ar_take && ar_idx == IDX_PBO) |=> (o_rvalid && o_rdata[TEST_BIT]);
    endproperty
    a_test_bit: assert property (p_test_bit)
        else $error("playback-only test bit did not read as one");

    property p_pbo_disable;
        @(posedge i_sys_clk) disable iff (i_sys_rst)
        regs.pbo[PBO_OFF] |=> !o_route.playback_allowed;
    endproperty
    a_pbo_disable: assert property (p_pbo_disable)
        else $error("playback-only disable not honoured");

    property p_preamp_eco;
        @(posedge i_sys_clk) disable iff (i_sys_rst)
        s_write_to(IDX_PBO, PRE_ECO) |-> s_route_settles
        ##0 o_route.preamp_eco;
    endproperty
    a_preamp_eco: assert property (p_preamp_eco)
        else $error("preamp power save write did not take effect");

    property p_pbo_right;
        @(posedge i_sys_clk) disable iff (i_sys_rst)
        (i_mode == MODE_PLAYBACK)
        |=> (o_route.opamp_right_on == $past(regs.pbo[OP_R]));
    endproperty
    a_pbo_right: assert property (p_pbo_right)
        else $error("opamp right channel wrong in playback-only");

    property p_pbo_left;
        @(posedge i_sys_clk) disable iff (i_sys_rst)
        (i_mode == MODE_PLAYBACK)
        |=> (o_route.opamp_left_on == $past(regs.pbo[OP_L]));
    endproperty
    a_pbo_left: assert property (p_pbo_left)
        else $error("opamp left channel wrong in playback-only");

    property p_nc_src;
        @(posedge i_sys_clk) disable iff (i_sys_rst)
        (i_mode == MODE_NC && regs.nc[SRC_HI:SRC_LO] == SRC_OPAMP)
        |=> (o_route.hp_from_opamp && !o_route.hp_from_mic);
    endproperty
    a_nc_src: assert property (p_nc_src)
        else $error("noise-cancel code 01 did not route the opamp");

    property p_reserved_zero;
        @(posedge i_sys_clk) disable iff (i_sys_rst)
        (ar_take && (ar_idx == IDX_MON || ar_idx == IDX_PBO))
        |=> ((o_rdata[REG_W-1:0] & ~MON_WMASK) == RST_VAL);
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved bits of a mode register read non-zero");

    property p_wr_resp;
        @(posedge i_sys_clk) disable iff (i_sys_rst)
        wr_commit |=> (o_bvalid && !o_awready && !o_wready);
    endproperty
    a_wr_resp: assert property (p_wr_resp)
        else $error("write response did not follow the commit");

    property p_unmapped_wr;
        @(posedge i_sys_clk) disable iff (i_sys_rst)
        (wr_commit && wr_msk == RST_VAL)
        |=> (o_bresp == RESP_SLVERR && regs == $past(regs));
    endproperty
    a_unmapped_wr: assert property (p_unmapped_wr)
        else $error("unmapped write was stored or answered okay");

    property p_rd_resp;
        @(posedge i_sys_clk) disable iff (i_sys_rst)
        ar_take |=> (o_rvalid && !o_arready
                     && o_rdata[DATA_W-1:REG_W] == '0);
    endproperty
    a_rd_resp: assert property (p_rd_resp)
        else $error("read data did not follow the address");

    property p_pbo_line;
        @(posedge i_sys_clk) disable iff (i_sys_rst)
        (i_mode == MODE_PLAYBACK)
        |=> (o_route.line_in_on && !o_route.hp_from_mic
             && !o_route.hp_from_opamp);
    endproperty
    a_pbo_line: assert property (p_pbo_line)
        else $error("playback-only routing is wrong");

    property p_nc_mute;
        @(posedge i_sys_clk) disable iff (i_sys_rst)
        (i_mode == MODE_NC)
        |=> (o_route.line_in_on == !$past(regs.nc[LMUTE]));
    endproperty
    a_nc_mute: assert property (p_nc_mute)
        else $error("line input mute in noise-cancel mode is wrong");

    property p_idle_off;
        @(posedge i_sys_clk) disable iff (i_sys_rst)
        (i_mode == MODE_IDLE)
        |=> !(o_route.line_in_on || o_route.hp_from_mic
              || o_route.hp_from_opamp || o_route.opamp_left_on
              || o_route.opamp_right_on);
    endproperty
    a_idle_off: assert property (p_idle_off)
        else $error("idle mode left a path switched on");

endmodule
`default_nettype wire

/* mpmr_pkg.sv */
// shared constants, types and decoders of the monitor / playback-only
// mode register bank; assumes an 8-bit register map behind AXI4-Lite
`default_nettype none
package mpmr_pkg;

    // ------------------------------------------------------------------
    // bus geometry and register indices (byte address = index * 4)
    // ------------------------------------------------------------------
    localparam int unsigned ADDR_W  = 8;
    localparam int unsigned DATA_W  = 32;
    localparam int unsigned REG_W   = 8;
    localparam int unsigned IDX_LSB = 2;
    localparam int unsigned IDX_W   = ADDR_W - IDX_LSB;

    localparam logic [IDX_W-1:0] IDX_NC  = 6'h14;
    localparam logic [IDX_W-1:0] IDX_MON = 6'h15;
    localparam logic [IDX_W-1:0] IDX_PBO = 6'h16;
    localparam logic [IDX_W-1:0] IDX_ECO = 6'h17;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int unsigned SRC_HI   = 7;
    localparam int unsigned SRC_LO   = 6;
    localparam int unsigned LMUTE    = 4;
    localparam int unsigned SLIDER   = 1;
    localparam int unsigned DIS_MON  = 0;
    localparam int unsigned TEST_BIT = 7;
    localparam int unsigned PBO_OFF  = 6;
    localparam int unsigned PRE_ECO  = 4;
    localparam int unsigned OP_R     = 1;
    localparam int unsigned OP_L     = 0;
    localparam int unsigned SLIDE_EN = 7;

    // ------------------------------------------------------------------
    // writable masks, fixed bits, reset values, codes
    // ------------------------------------------------------------------
    localparam logic [REG_W-1:0] NC_WMASK  = 8'hd3;
    localparam logic [REG_W-1:0] MON_WMASK = 8'hd3;
    localparam logic [REG_W-1:0] PBO_WMASK = 8'h53;
    localparam logic [REG_W-1:0] ECO_WMASK = 8'h80;
    localparam logic [REG_W-1:0] PBO_FIXED = 8'h80;
    localparam logic [REG_W-1:0] RST_VAL   = 8'h00;

    localparam logic [1:0] SRC_MIC   = 2'h0;
    localparam logic [1:0] SRC_OPAMP = 2'h1;
    localparam logic [1:0] SRC_RSVD  = 2'h2;
    localparam logic [1:0] SRC_NONE  = 2'h3;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        MODE_NC,
        MODE_MONITOR,
        MODE_PLAYBACK,
        MODE_IDLE
    } mpmr_mode_t;

    typedef struct packed {
        logic [REG_W-1:0] nc;
        logic [REG_W-1:0] mon;
        logic [REG_W-1:0] pbo;
        logic [REG_W-1:0] eco;
    } mpmr_regs_t;

    typedef struct packed {
        logic hp_from_mic;
        logic hp_from_opamp;
        logic line_in_on;
        logic opamp_left_on;
        logic opamp_right_on;
        logic preamp_eco;
        logic monitor_allowed;
        logic playback_allowed;
        logic full_slider;
        logic slide_power_on;
    } mpmr_route_t;

    // source selector -> {mic path, opamp path}; reserved acts as none
    function automatic logic [1:0] hp_connect(input logic [1:0] sel);
        case (sel)
            SRC_MIC:   hp_connect = 2'h2;
            SRC_OPAMP: hp_connect = 2'h1;
            default:   hp_connect = 2'h0;
        endcase
    endfunction

    // writable mask of a register; zero marks an unmapped index
    function automatic logic [REG_W-1:0] wr_mask(
        input logic [IDX_W-1:0] idx
    );
        case (idx)
            IDX_NC:  wr_mask = NC_WMASK;
            IDX_MON: wr_mask = MON_WMASK;
            IDX_PBO: wr_mask = PBO_WMASK;
            IDX_ECO: wr_mask = ECO_WMASK;
            default: wr_mask = RST_VAL;
        endcase
    endfunction

endpackage
`default_nettype wire

/* mpmr_route.sv */
// registered routing / amplifier enables from the mode registers;
// assumes the active mode comes synchronous to i_sys_clk
`timescale 1ns/1ns
`default_nettype none
module mpmr_route (
    input  wire logic                 i_sys_clk, // system clock
    input  wire logic                 i_sys_rst, // async reset, high
    input  wire mpmr_pkg::mpmr_mode_t i_mode,    // active operating mode
    input  wire mpmr_pkg::mpmr_regs_t i_regs,    // register contents
    output var  mpmr_pkg::mpmr_route_t o_route   // registered controls
);
    import mpmr_pkg::*;

    mpmr_route_t next_route;
    logic [1:0]  mon_path;
    logic [1:0]  nc_path;

    assign mon_path = hp_connect(i_regs.mon[SRC_HI:SRC_LO]);
    assign nc_path  = hp_connect(i_regs.nc[SRC_HI:SRC_LO]);

    always_comb begin
        next_route = '0;
        next_route.preamp_eco       = i_regs.pbo[PRE_ECO];
        next_route.monitor_allowed  = !i_regs.mon[DIS_MON];
        next_route.playback_allowed = !i_regs.pbo[PBO_OFF];
        next_route.slide_power_on   = i_regs.eco[SLIDE_EN];
        // full slider only once slide power control is on
        next_route.full_slider = i_regs.mon[SLIDER]
                               & i_regs.eco[SLIDE_EN];
        case (i_mode)
            MODE_NC: begin
                next_route.hp_from_mic    = nc_path[1];
                next_route.hp_from_opamp  = nc_path[0];
                next_route.line_in_on     = !i_regs.nc[LMUTE];
                next_route.opamp_left_on  = i_regs.nc[OP_L];
                next_route.opamp_right_on = i_regs.nc[OP_R];
            end
            MODE_MONITOR: begin
                next_route.hp_from_mic    = mon_path[1];
                next_route.hp_from_opamp  = mon_path[0];
                next_route.line_in_on     = !i_regs.mon[LMUTE];
                next_route.opamp_left_on  = mon_path[0];
                next_route.opamp_right_on = mon_path[0];
            end
            MODE_PLAYBACK: begin
                next_route.line_in_on     = 1'b1;
                next_route.opamp_left_on  = i_regs.pbo[OP_L];
                next_route.opamp_right_on = i_regs.pbo[OP_R];
            end
            default: begin
                next_route.line_in_on     = 1'b0;
            end
        endcase
    end

    always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_route <= '0;
        end else begin
            o_route <= next_route;
        end
    end

endmodule
`default_nettype wire

/* mpmr_regs_test.sv */
// self-checking bench for the monitor / playback-only mode register bank
// assumes mpmr_pkg is compiled first; drives the AXI4-Lite slave directly
`timescale 1ns/1ns
`default_nettype none
module mpmr_regs_test;
    import mpmr_pkg::*;

    // ------------------------------------------------------------------
    // signals
    // ------------------------------------------------------------------
    localparam int CEIL = 5000;
    logic                i_sys_clk;
    logic                i_sys_rst;
    mpmr_mode_t          mode;
    logic [ADDR_W-1:0]   awaddr;
    logic [ADDR_W-1:0]   araddr;
    logic [DATA_W-1:0]   wdata;
    logic [DATA_W-1:0]   rdata;
    logic [DATA_W-1:0]   data;
    logic [3:0]          wstrb;
    logic [1:0]          bresp;
    logic [1:0]          rresp;
    logic [1:0]          resp;
    logic                awvalid;
    logic                awready;
    logic                wvalid;
    logic                wready;
    logic                bvalid;
    logic                bready;
    logic                arvalid;
    logic                arready;
    logic                rvalid;
    logic                rready;
    mpmr_route_t         route;
    int                  failures;
    int                  cmp_count;
    int                  cycles;

    mpmr_regs u_mpmr_regs (
        .i_sys_clk (i_sys_clk),
        .i_sys_rst (i_sys_rst),
        .i_mode    (mode),
        .i_awaddr  (awaddr),
        .i_awvalid (awvalid),
        .o_awready (awready),
        .i_wdata   (wdata),
        .i_wstrb   (wstrb),
        .i_wvalid  (wvalid),
        .o_wready  (wready),
        .o_bresp   (bresp),
        .o_bvalid  (bvalid),
        .i_bready  (bready),
        .i_araddr  (araddr),
        .i_arvalid (arvalid),
        .o_arready (arready),
        .o_rdata   (rdata),
        .o_rresp   (rresp),
        .o_rvalid  (rvalid),
        .i_rready  (rready),
        .o_route   (route)
    );

    // ------------------------------------------------------------------
    // clock, watchdog, helpers
    // ------------------------------------------------------------------
    initial begin
        i_sys_clk = 1'b0;
        forever #25 i_sys_clk = ~i_sys_clk;
    end

    task automatic conclude;
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    always @(posedge i_sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == CEIL) begin
            failures++;
            conclude();
        end
    end

    task automatic chk(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic bchk(input string nm, input logic seen, input logic exp);
        chk(nm, {31'h0, seen}, {31'h0, exp});
    endtask

    // write: aw and w offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_sys_clk);
        awaddr  <= a;
        awvalid <= 1'b1;
        wdata   <= {24'h0, d};
        wstrb   <= 4'h1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do begin
            @(posedge i_sys_clk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        resp = bresp;
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge i_sys_clk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do begin
            @(posedge i_sys_clk);
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        data = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask

    // write, then let the registered routing follow
    task automatic wrs(input logic [7:0] a, input logic [7:0] d);
        wr(a, d);
        chk("bresp", {30'h0, resp}, {30'h0, RESP_OKAY});
        repeat (2) @(posedge i_sys_clk);
    endtask

    // ------------------------------------------------------------------
    // tests
    // ------------------------------------------------------------------
    initial begin
        logic [7:0] rst_exp [4];
        rst_exp = '{8'h00, 8'h00, 8'h80, 8'h00};
        failures = 0;
        cmp_count = 0;
        cycles = 0;
        i_sys_rst = 1'b1;
        mode = MODE_MONITOR;
        {awaddr, araddr, wdata, wstrb} = '0;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        repeat (8) @(posedge i_sys_clk);
        i_sys_rst <= 1'b0;

        for (int i = 0; i < 4; i++) begin
            rd(8'h50 + 8'(i * 4));
            chk("reset value", data, {24'h0, rst_exp[i]});
            chk("rresp", {30'h0, resp}, {30'h0, RESP_OKAY});
        end
        $display("test reset values done");

        wr(8'h54, 8'hff);
        rd(8'h54);
        chk("monitor readback", data, 32'h0000_00d3);
        wr(8'h58, 8'h2c);
        rd(8'h58);
        chk("playback reserved", data, 32'h0000_0080);
        wr(8'h58, 8'h53);
        rd(8'h58);
        chk("playback readback", data, 32'h0000_00d3);
        wr(8'h40, 8'hff);
        chk("unmapped bresp", {30'h0, resp}, {30'h0, RESP_SLVERR});
        rd(8'h40);
        chk("unmapped rresp", {30'h0, resp}, {30'h0, RESP_SLVERR});
        chk("unmapped rdata", data, 32'h0);
        $display("test access kinds done");

        mode <= MODE_MONITOR;
        for (int c = 0; c < 4; c++) begin
            if (c == 2) continue;
            wrs(8'h54, {2'(c), 6'h0});
            bchk("mon src mic", route.hp_from_mic, c == 0);
            bchk("mon src opamp", route.hp_from_opamp, c == 1);
            bchk("mon opamp on", route.opamp_left_on, c == 1);
        end
        wrs(8'h54, 8'h11);
        bchk("mon line in", route.line_in_on, 1'b0);
        bchk("mon allowed", route.monitor_allowed, 1'b0);
        wrs(8'h54, 8'h00);
        bchk("mon line in", route.line_in_on, 1'b1);
        bchk("mon allowed", route.monitor_allowed, 1'b1);
        bchk("slide power", route.slide_power_on, 1'b0);
        wrs(8'h5c, 8'h80);
        bchk("slide power", route.slide_power_on, 1'b1);
        bchk("full slider", route.full_slider, 1'b0);
        wrs(8'h54, 8'h02);
        bchk("full slider", route.full_slider, 1'b1);
        wrs(8'h54, 8'h00);
        bchk("basic slider", route.full_slider, 1'b0);
        $display("test monitor routing done");

        mode <= MODE_PLAYBACK;
        wrs(8'h58, 8'h01);
        bchk("pbo left", route.opamp_left_on, 1'b1);
        bchk("pbo right", route.opamp_right_on, 1'b0);
        bchk("pbo allowed", route.playback_allowed, 1'b1);
        bchk("pbo eco", route.preamp_eco, 1'b0);
        bchk("pbo line in", route.line_in_on, 1'b1);
        wrs(8'h58, 8'h52);
        bchk("pbo left", route.opamp_left_on, 1'b0);
        bchk("pbo right", route.opamp_right_on, 1'b1);
        bchk("pbo allowed", route.playback_allowed, 1'b0);
        bchk("pbo eco", route.preamp_eco, 1'b1);
        $display("test playback routing done");

        mode <= MODE_NC;
        for (int c = 0; c < 4; c++) begin
            if (c == 2) continue;
            wrs(8'h50, {2'(c), 6'h0});
            bchk("nc src mic", route.hp_from_mic, c == 0);
            bchk("nc src opamp", route.hp_from_opamp, c == 1);
        end
        wrs(8'h50, 8'h13);
        bchk("nc line in", route.line_in_on, 1'b0);
        bchk("nc opamp left", route.opamp_left_on, 1'b1);
        bchk("nc opamp right", route.opamp_right_on, 1'b1);
        $display("test noise cancel routing done");

        mode <= MODE_IDLE;
        repeat (2) @(posedge i_sys_clk);
        bchk("idle line in", route.line_in_on, 1'b0);
        bchk("idle opamp", route.opamp_left_on, 1'b0);
        $display("test idle mode done");
        conclude();
    end
endmodule
`default_nettype wire
